// File: hdl/fwp_controller.sv
`timescale 1ns/1ps
module fwp_controller
    import fwp_pkg::*;
#(
    parameter bit TOP_BOOT = 1'b0
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [WB_AW-1:0]  adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [WB_DW-1:0]  dat_i,
    output logic      [WB_DW-1:0]  dat_o,
    output logic                   ack_o,
    output logic                   flashCeN,
    output logic                   flashOeN,
    output logic                   flashWeN,
    output logic      [ADDR_W-1:0] flashAddr,
    output logic      [DATA_W-1:0] flashDataOut,
    output logic                   flashDataOe,
    input  wire logic [DATA_W-1:0] flashDataIn,
    output logic                   flashResetN,
    output logic                   flashHvReq,
    output logic                   protectAccelPinN,
    input  wire logic              supplyLowIn
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    fwp_op_t           op_q;
    fwp_state_t        state_q;
    fwp_state_t        state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [2:0]        step_q;
    logic              secured_q;
    logic              factory_q;
    logic              refused_q;
    logic              rstPin_q;
    logic [DATA_W:0]   syncLevel;

    // pins from the flash side are not on our clock
    fwp_pin_sync #(
        .WIDTH(DATA_W + 1)
    ) u_sync (
        .sys_clk(sys_clk),
        .srst   (srst),
        .pinIn  ({supplyLowIn, flashDataIn}),
        .level  (syncLevel)
    );

    // lockout and read data kept separate
    wire              supplyLowS = syncLevel[DATA_W];
    wire [DATA_W-1:0] dataInS    = syncLevel[DATA_W-1:0];

    // wishbone decode; write lands on the edge that sees ack
    wire        wbReq    = cyc_i & stb_i;
    wire        wbWrite  = wbReq & we_i & ack_o;
    wire [31:0] laneMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire        hitCtrl  = adr_i == REG_CTRL;
    wire        hitAddr  = adr_i == REG_ADDR;
    wire        hitWdata = adr_i == REG_WDATA;
    wire        hitCmd   = adr_i == REG_CMD;
    wire        hitStat  = adr_i == REG_STAT;
    wire        hitRdata = adr_i == REG_RDATA;
    wire        cmdWrite = wbWrite & hitCmd & sel_i[0];
    wire [31:0] ctrlNew  = ({29'h0, ctrl_q} & ~laneMask) | (dat_i & laneMask);
    wire [31:0] addrNew  = ({12'h0, addr_q} & ~laneMask) | (dat_i & laneMask);
    wire [31:0] wdataNew = ({16'h0, wdata_q} & ~laneMask) | (dat_i & laneMask);
    wire        busy     = state_q != ST_IDLE;
    wire [31:0] statWord = {27'h0, factory_q, refused_q, supplyLowS, secured_q, busy};
    wire [31:0] rdWord   = hitCtrl  ? {29'h0, ctrl_q} :
                           hitAddr  ? {12'h0, addr_q} :
                           hitWdata ? {16'h0, wdata_q} :
                           hitStat  ? statWord :
                           hitRdata ? {16'h0, rdata_q} : 32'h0;

    // outer pair is the lowest or the highest 8K words
    wire [ADDR_W-BOOT_LO-1:0] bootField = addr_q[ADDR_W-1:BOOT_LO];
    wire bootHit = TOP_BOOT ? (&bootField) : ~(|bootField);
    // region window is 32K words over the boot end
    // serial words sit inside this window
    wire [ADDR_W-SEC_LO-1:0] secField = addr_q[ADDR_W-1:SEC_LO];
    wire secHit = TOP_BOOT ? (&secField) : ~(|secField);

    fwp_op_t newOp;
    assign newOp = fwp_op_t'(dat_i[OP_W-1:0]);
    wire isModify = (newOp == OP_PROG) | (newOp == OP_ERASE);
    wire wpLow    = ~ctrl_q[CTRL_WP_BIT];
    wire inReset  = ctrl_q[CTRL_RST_BIT];
    // pin low means outer boot sectors never written
    // same holds while the reset pin carries high voltage
    wire bootGuard = isModify & bootHit & wpLow & ~secured_q;
    // a factory-locked region is never written
    wire lockGuard = isModify & secured_q & factory_q;
    // in region mode program, erase and read touch only the region window
    wire winGuard  = secured_q & (isModify | (newOp == OP_READ)) & ~secHit;
    // nothing is sent below the lockout threshold
    // nor while the supply is still coming up
    wire refuse  = busy | supplyLowS | inReset | bootGuard | lockGuard | winGuard;
    wire start   = cmdWrite & ~refuse;
    wire abort   = supplyLowS | inReset;

    // one bus cycle of the current step: {read, last, address, data}
    function automatic logic [ADDR_W+DATA_W+1:0] stepOf(
        input fwp_op_t           op,
        input logic [2:0]        idx,
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d
    );
        logic [ADDR_W+DATA_W+1:0] s;
        s = {1'b0, 1'b1, a, CMD_RESET};
        // every program, erase or mode change opens with the unlock pair
        if (op != OP_READ && op != OP_WRITE && op != OP_RESET && idx == 3'h0) begin
            s = {1'b0, 1'b0, UNLOCK_ADDR1, UNLOCK_DATA1};
        end else if (op != OP_READ && op != OP_WRITE && op != OP_RESET && idx == 3'h1) begin
            s = {1'b0, 1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
        end else begin
            case (op)
                OP_READ:  s = {1'b1, 1'b1, a, d};
                // raw cycles carry the protect algorithm in region mode
                OP_WRITE: s = {1'b0, 1'b1, a, d};
                // plain program only, accelerate and bypass never used
                OP_PROG:  s = (idx == 3'h2) ? {1'b0, 1'b0, UNLOCK_ADDR1, CMD_PROGRAM}
                                            : {1'b0, 1'b1, a, d};
                OP_ERASE: begin
                    case (idx)
                        3'h2:    s = {1'b0, 1'b0, UNLOCK_ADDR1, CMD_ERASE};
                        3'h3:    s = {1'b0, 1'b0, UNLOCK_ADDR1, UNLOCK_DATA1};
                        3'h4:    s = {1'b0, 1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
                        default: s = {1'b0, 1'b1, a, CMD_SECTOR};
                    endcase
                end
                OP_ENTER: s = {1'b0, 1'b1, UNLOCK_ADDR1, CMD_ENTER};
                OP_EXIT:  s = (idx == 3'h2) ? {1'b0, 1'b0, UNLOCK_ADDR1, CMD_AUTOSEL}
                                            : {1'b0, 1'b1, a, CMD_EXIT};
                OP_IDREAD: begin
                    case (idx)
                        3'h2:    s = {1'b0, 1'b0, UNLOCK_ADDR1, CMD_AUTOSEL};
                        3'h3:    s = {1'b1, 1'b0, ID_ADDR, d};
                        default: s = {1'b0, 1'b1, a, CMD_RESET};
                    endcase
                end
                default:  s = {1'b0, 1'b1, a, CMD_RESET};
            endcase
        end
        return s;
    endfunction

    wire [ADDR_W+DATA_W+1:0] step = stepOf(op_q, step_q, addr_q, wdata_q);
    wire              stRead = step[ADDR_W+DATA_W+1];
    wire              stLast = step[ADDR_W+DATA_W];
    wire [ADDR_W-1:0] stAddr = step[ADDR_W+DATA_W-1:DATA_W];
    wire [DATA_W-1:0] stData = step[DATA_W-1:0];
    wire              cntZero = cnt_q == '0;
    wire              stepEnd = (state_q == ST_GAP) & cntZero;
    wire              opDone  = stepEnd & stLast;
    wire              sample  = (state_q == ST_STROBE) & cntZero & stRead;

    // bus-cycle sequencer: setup, strobe, hold, gap per step
    always_comb begin
        state_d = state_q;
        cnt_d   = cntZero ? cnt_q : cnt_q - 1'b1;
        case (state_q)
            ST_IDLE:   if (start) state_d = ST_SETUP;
            ST_SETUP: begin
                state_d = ST_STROBE;
                cnt_d   = stRead ? CNT_W'(RD_CYC - 1) : CNT_W'(WE_CYC - 1);
            end
            ST_STROBE: if (cntZero) state_d = ST_HOLD;
            ST_HOLD: begin
                state_d = ST_GAP;
                cnt_d   = CNT_W'(GAP_CYC - 1);
            end
            ST_GAP:    if (cntZero) state_d = stLast ? ST_IDLE : ST_SETUP;
            default:   state_d = ST_IDLE;
        endcase
        // lockout drops the cycle in flight
        if (abort) state_d = ST_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            step_q  <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            step_q  <= (start | opDone) ? 3'h0 : step_q + {2'h0, stepEnd};
        end
    end

    // software registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q  <= CTRL_RESET_VAL;
            addr_q  <= '0;
            wdata_q <= '0;
            op_q    <= OP_READ;
        end else begin
            if (wbWrite & hitCtrl) ctrl_q <= ctrlNew[CTRL_W-1:0];
            if (wbWrite & hitAddr & ~busy) addr_q <= addrNew[ADDR_W-1:0];
            if (wbWrite & hitWdata & ~busy) wdata_q <= wdataNew[DATA_W-1:0];
            if (start) op_q <= newOp;
        end
    end

    // region mode and indicator tracking
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            secured_q <= 1'b0;
            factory_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q   <= '0;
            rstPin_q  <= 1'b0;
        end else begin
            rstPin_q <= inReset;
            if (cmdWrite) refused_q <= refuse;
            if (sample) rdata_q <= dataInS;
            // indicator one marks a factory-locked region
            if (sample & (op_q == OP_IDREAD)) factory_q <= dataInS[INDICATOR_BIT];
            // reset pulse or lost supply leaves region mode
            if ((inReset & ~rstPin_q) | supplyLowS) begin
                secured_q <= 1'b0;
            end else if (opDone & (op_q == OP_ENTER)) begin
                // boot addresses now reach the region
                secured_q <= 1'b1;
            end else if (opDone & (op_q == OP_EXIT)) begin
                secured_q <= 1'b0;
            end
        end
    end

    // pins registered from the state decode so they never glitch
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flashCeN     <= 1'b1;
            flashOeN     <= 1'b1;
            flashWeN     <= 1'b1;
            flashAddr    <= '0;
            flashDataOut <= '0;
            flashDataOe  <= 1'b0;
        end else begin
            flashCeN     <= ~(state_q inside {ST_SETUP, ST_STROBE, ST_HOLD});
            // strobe only with select low and output enable high
            flashWeN     <= ~((state_q == ST_STROBE) & ~stRead);
            flashOeN     <= ~((state_q == ST_STROBE) & stRead);
            flashAddr    <= stAddr;
            flashDataOut <= stData;
            flashDataOe  <= (state_q inside {ST_SETUP, ST_STROBE, ST_HOLD}) & ~stRead;
        end
    end

    // high voltage request starts temporary unprotect
    // dropping it restores the former protection
    // pin high lets the stored protection govern
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flashResetN      <= 1'b0;
            flashHvReq       <= 1'b0;
            protectAccelPinN <= 1'b1;
            ack_o            <= 1'b0;
            dat_o            <= '0;
        end else begin
            flashResetN      <= ~inReset;
            flashHvReq       <= ctrl_q[CTRL_HV_BIT] & ~inReset;
            protectAccelPinN <= ctrl_q[CTRL_WP_BIT];
            ack_o            <= wbReq & ~ack_o;
            if (wbReq & ~ack_o) dat_o <= rdWord;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    write_strobe_a: assert property (!flashWeN |-> !flashCeN && flashOeN)
        else $error("write strobe without select or with output enable");
    data_drive_a: assert property (disable iff (srst || abort)
        !flashWeN |-> flashDataOe && !flashCeN ##1 flashDataOe)
        else $error("data not driven around write strobe");
    low_supply_a: assert property (supplyLowS |-> ##2 flashWeN && flashCeN)
        else $error("flash cycle continues under lockout");
    boot_guard_a: assert property (cmdWrite && bootGuard && !busy |=> refused_q && !busy)
        else $error("outer boot sector write not refused");
    lock_guard_a: assert property (cmdWrite && lockGuard && !busy |=>
        refused_q && state_q == ST_IDLE)
        else $error("factory-locked region write not refused");
    secured_exit_a: assert property ($rose(inReset) |=> !secured_q)
        else $error("region mode survives reset pulse");
    ack_pulse_a: assert property (wbReq && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single cycle one wait state");
    strobe_len_a: assert property (disable iff (srst || abort)
        $fell(flashWeN) |-> (!flashWeN)[*7] ##1 flashWeN)
        else $error("write strobe width wrong");
    unlock_first_a: assert property (start && isModify |=> step_q == 3'h0 ##1
        stAddr == UNLOCK_ADDR1 && stData == UNLOCK_DATA1)
        else $error("program or erase without leading unlock cycle");
endmodule

// File: hdl/fwp_pin_sync.sv
`timescale 1ns/1ps
module fwp_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // three stages; a bit moves only when stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            level <= '0;
        end else begin
            s1_q  <= pinIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= (s2_q & s3_q) | (level & (s2_q ^ s3_q));
        end
    end
endmodule

// File: hdl/fwp_pkg.sv
package fwp_pkg;
    // bus and flash widths
    localparam int WB_AW  = 8;
    localparam int WB_DW  = 32;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // register byte offsets on the wishbone side
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD   = 8'h0C;
    localparam logic [7:0] REG_STAT  = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;

    // control field positions and reset value
    localparam int CTRL_W       = 3;
    localparam int CTRL_WP_BIT  = 0;
    localparam int CTRL_HV_BIT  = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 3'h1;

    // status field positions
    localparam int STAT_BUSY    = 0;
    localparam int STAT_SECURED = 1;
    localparam int STAT_SUPPLY  = 2;
    localparam int STAT_REFUSED = 3;
    localparam int STAT_FACTORY = 4;

    // command field in the command register
    localparam int OP_W = 3;

    // timing at the system clock rate
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_WE_NS       = 35;
    localparam int T_ACC_NS      = 70;
    localparam int T_GAP_NS      = 20;
    localparam int SYNC_LAT      = 4;
    localparam int PIN_LAT       = 1;

    // least times round up, never below one cycle
    function automatic int cyclesCeil(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WE_CYC  = cyclesCeil(T_WE_NS);
    localparam int ACC_CYC = cyclesCeil(T_ACC_NS);
    localparam int GAP_CYC = cyclesCeil(T_GAP_NS);
    localparam int RD_CYC  = ACC_CYC + SYNC_LAT + PIN_LAT;
    localparam int CNT_W   = 8;

    // standard command-set cycles
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 20'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 20'h002AA;
    localparam logic [ADDR_W-1:0] ID_ADDR      = 20'h00003;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROGRAM  = 16'h00A0;
    localparam logic [DATA_W-1:0] CMD_ERASE    = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_SECTOR   = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_ENTER    = 16'h0088;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL  = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_EXIT     = 16'h0000;
    localparam logic [DATA_W-1:0] CMD_RESET    = 16'h00F0;
    localparam int INDICATOR_BIT = 7;

    // two outer 8 Kbyte sectors span 8K words; secured region 64 Kbytes = 32K words
    localparam int BOOT_LO = 13;
    localparam int SEC_LO  = 15;

    typedef enum logic [OP_W-1:0] {
        OP_READ   = 3'h0,
        OP_WRITE  = 3'h1,
        OP_PROG   = 3'h2,
        OP_ERASE  = 3'h3,
        OP_ENTER  = 3'h4,
        OP_EXIT   = 3'h5,
        OP_RESET  = 3'h6,
        OP_IDREAD = 3'h7
    } fwp_op_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h2,
        ST_HOLD   = 3'h3,
        ST_GAP    = 3'h4
    } fwp_state_t;
endpackage

// File: tb/fwp_controller_bench.sv
`timescale 1ns/1ps
module fwp_controller_bench;
    import fwp_pkg::*;
    logic              sys_clk = 1'h0;
    logic              srst = 1'h1;
    logic              cyc_i = 1'h0;
    logic              stb_i = 1'h0;
    logic              we_i = 1'h0;
    logic [7:0]        adr_i = 8'h00;
    logic [3:0]        sel_i = 4'hF;
    logic [31:0]       dat_i = 32'h0;
    logic              supplyLowIn = 1'h0;
    logic [31:0]       dat_o;
    logic              ack_o, flashCeN, flashOeN, flashWeN, flashDataOe;
    logic              flashResetN, flashHvReq, protectAccelPinN;
    logic [19:0]       flashAddr;
    logic [15:0]       flashDataOut, flashDataIn;
    int                nErrors = 0;
    int                samplesChecked = 0;
    int                seed = 49;
    logic              factoryPart = 1'h0;
    logic [63:0]       expQ [$];
    logic [63:0]       note;
    logic [31:0]       rdSeen;
    logic [15:0]       dA, dB;
    logic [19:0]       midA;

    fwp_controller #(.TOP_BOOT(1'h0)) u_dut (.sys_clk(sys_clk), .srst(srst), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .flashCeN(flashCeN), .flashOeN(flashOeN),
        .flashWeN(flashWeN), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
        .flashDataOe(flashDataOe), .flashDataIn(flashDataIn), .flashResetN(flashResetN),
        .flashHvReq(flashHvReq), .protectAccelPinN(protectAccelPinN),
        .supplyLowIn(supplyLowIn));
    fwp_flash_model u_flash (.factory(factoryPart), .ceN(flashCeN), .oeN(flashOeN),
        .weN(flashWeN), .addr(flashAddr), .din(flashDataOut), .resetN(flashResetN),
        .hvOn(flashHvReq), .wpN(protectAccelPinN), .supplyLow(supplyLowIn), .dout(flashDataIn));

    // free-running system clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // one classic cycle, held until ack is seen
    // only the watchdog ends a wait for the answer
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge sys_clk);
        end while (ack_o !== 1'h1);
        rdSeen = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge sys_clk);
    endtask
    // a zero mask notes a read that is not compared
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back({e, m});
        wb(1'h0, a, 32'h0);
    endtask
    task automatic waitIdle;
        do begin
            rd(REG_STAT, 32'h0, 32'h0);
        end while (rdSeen[STAT_BUSY] !== 1'h0);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
        wb(1'h1, REG_ADDR, {12'h000, a});
        wb(1'h1, REG_WDATA, {16'h0000, d});
        wb(1'h1, REG_CMD, {29'h0, op});
        waitIdle();
    endtask
    task automatic progChk(input logic [19:0] a, input logic [15:0] d, input logic [15:0] e,
                           input logic refused);
        cmd(OP_PROG, a, d);
        rd(REG_STAT, 32'(refused) << STAT_REFUSED, 32'h1 << STAT_REFUSED);
        cmd(OP_READ, a, 16'h0);
        rd(REG_RDATA, {16'h0000, e}, 32'hFFFF);
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d errors %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // each read answer against the oldest note
    always @(posedge sys_clk) begin
        if (ack_o === 1'h1 && we_i === 1'h0 && expQ.size() > 0) begin
            note = expQ.pop_front();
            if (note[31:0] != 32'h0) begin
                samplesChecked++;
                if ((dat_o & note[31:0]) !== note[63:32]) begin
                    nErrors++;
                    $display("BAD reg %h expected %h seen %h", adr_i, note[63:32],
                             dat_o & note[31:0]);
                end
            end
        end
    end
    // watchdog, well beyond the expected run
    initial begin
        repeat (40000) @(posedge sys_clk);
        nErrors++;
        tallyAndFinish();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'h0;
        @(posedge sys_clk);
        dA = 16'($random(seed));
        dB = 16'($random(seed));
        midA = {2'h1, 18'($random(seed))};
        rd(REG_CTRL, {29'h0, CTRL_RESET_VAL}, 32'h7);
        wb(1'h1, 8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
        rd(REG_CMD, 32'h0, 32'hFFFFFFFF);
        // plain program and erase in the middle of the array
        progChk(midA, dA, dA, 1'h0);
        cmd(OP_ERASE, midA, 16'h0);
        cmd(OP_READ, midA, 16'h0);
        rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
        // protect pin low guards only the low pair in a bottom part
        wb(1'h1, REG_CTRL, 32'h0);
        progChk(20'h00100, dA, 16'hFFFF, 1'h1);
        progChk(20'hFE000, dB, dB, 1'h0);
        wb(1'h1, REG_CTRL, 32'h1);
        progChk(20'h00100, dA, 16'hFFFF, 1'h0);
        // high voltage on the reset pin lifts the stored lock for a while
        wb(1'h1, REG_CTRL, 32'h3);
        progChk(20'h00100, dA, dA, 1'h0);
        wb(1'h1, REG_CTRL, 32'h2);
        progChk(20'h00180, dB, 16'hFFFF, 1'h1);
        wb(1'h1, REG_CTRL, 32'h1);
        progChk(20'h00180, dB, 16'hFFFF, 1'h0);
        // region mode overlays the boot area, exit brings it back
        cmd(OP_ENTER, 20'h0, 16'h0);
        rd(REG_STAT, 32'h1 << STAT_SECURED, 32'h1 << STAT_SECURED);
        progChk(20'h00100, dB, dB, 1'h0);
        cmd(OP_READ, 20'h08000, 16'h0);
        rd(REG_STAT, 32'h8, 32'h8);
        cmd(OP_READ, 20'h00007, 16'h0);
        rd(REG_STAT, 32'h0, 32'h8);
        cmd(OP_EXIT, 20'h0, 16'h0);
        rd(REG_STAT, 32'h0, 32'h1 << STAT_SECURED);
        cmd(OP_READ, 20'h00100, 16'h0);
        rd(REG_RDATA, {16'h0000, dA}, 32'hFFFF);
        cmd(OP_IDREAD, 20'h0, 16'h0);
        rd(REG_RDATA, 32'h0, 32'h80);
        rd(REG_STAT, 32'h0, 32'h1 << STAT_FACTORY);
        // a half unlock dropped by reset must not spoil the next program
        cmd(OP_WRITE, UNLOCK_ADDR1, UNLOCK_DATA1);
        cmd(OP_RESET, 20'h0, 16'h0);
        progChk(midA + 20'h10, dB, dB, 1'h0);
        // supply below lockout
        cmd(OP_ENTER, 20'h0, 16'h0);
        supplyLowIn <= 1'h1;
        repeat (8) @(posedge sys_clk);
        rd(REG_STAT, 32'h4, 32'h6);
        cmd(OP_PROG, midA, dA);
        rd(REG_STAT, 32'h8, 32'h8);
        supplyLowIn <= 1'h0;
        repeat (8) @(posedge sys_clk);
        cmd(OP_READ, midA, 16'h0);
        rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
        // hardware reset leaves region mode
        cmd(OP_ENTER, 20'h0, 16'h0);
        wb(1'h1, REG_CTRL, 32'h5);
        rd(REG_STAT, 32'h0, 32'h1 << STAT_SECURED);
        cmd(OP_READ, midA, 16'h0);
        rd(REG_STAT, 32'h8, 32'h8);
        wb(1'h1, REG_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk);
        cmd(OP_READ, 20'h00100, 16'h0);
        rd(REG_RDATA, {16'h0000, dA}, 32'hFFFF);
        // factory part: indicator one, region refuses program
        factoryPart <= 1'h1;
        cmd(OP_IDREAD, 20'h0, 16'h0);
        rd(REG_RDATA, 32'h80, 32'h80);
        rd(REG_STAT, 32'h1 << STAT_FACTORY, 32'h1 << STAT_FACTORY);
        cmd(OP_ENTER, 20'h0, 16'h0);
        progChk(20'h00100, dA, dB, 1'h1);
        tallyAndFinish();
    end
endmodule

// File: tb/fwp_flash_model.sv
`timescale 1ns/1ps
module fwp_flash_model
    import fwp_pkg::*;
#(
    parameter bit OUTER_LOCKED = 1'h1
) (
    input  wire logic              factory,
    input  wire logic              ceN,
    input  wire logic              oeN,
    input  wire logic              weN,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] din,
    input  wire logic              resetN,
    input  wire logic              hvOn,
    input  wire logic              wpN,
    input  wire logic              supplyLow,
    output logic      [DATA_W-1:0] dout
);
    logic [DATA_W-1:0] mem [logic [ADDR_W:0]];
    logic [DATA_W-1:0] rdv     = 16'h0000;
    logic [DATA_W-1:0] lastQ   = 16'h0000;
    logic              region  = 1'h0;
    logic              autoSel = 1'h0;
    int                step    = 0;
    // window over the low boot area
    wire               inWin   = region && ~|addr[19:SEC_LO];
    wire  [ADDR_W:0]   key     = {inWin, addr};
    wire locked = (~|addr[19:BOOT_LO] && !inWin && (!wpN || (OUTER_LOCKED && !hvOn)))
                  || (inWin && factory);
    // word latched as the read starts
    always @(negedge oeN) begin
        rdv = (autoSel && addr == ID_ADDR) ? {8'h00, factory, 7'h01} :
              mem.exists(key) ? mem[key] : 16'hFFFF;
    end
    // released bus shows the inverse, never a stale copy
    always @(posedge oeN) begin
        lastQ = rdv;
    end
    assign dout = (!ceN && !oeN) ? rdv : ~lastQ;
    always @(posedge weN or negedge resetN or posedge supplyLow) begin
        if (!resetN || supplyLow) begin
            step = 0;
            autoSel = 1'h0;
            region = 1'h0;
        end else if (!ceN && oeN) begin
            case (step)
                0: begin
                    if (autoSel && din == CMD_EXIT) region = 1'h0;
                    if (din == CMD_EXIT || din == CMD_RESET) autoSel = 1'h0;
                    step = (addr == UNLOCK_ADDR1 && din == UNLOCK_DATA1) ? 1 : 0;
                end
                1, 4: step = (addr == UNLOCK_ADDR2 && din == UNLOCK_DATA2) ? step + 1 : 0;
                2: begin
                    region = region || din == CMD_ENTER;
                    autoSel = din == CMD_AUTOSEL;
                    step = (din == CMD_PROGRAM) ? 10 : (din == CMD_ERASE) ? 3 : 0;
                end
                3: step = (addr == UNLOCK_ADDR1 && din == UNLOCK_DATA1) ? 4 : 0;
                // erase clears only the addressed word, enough for read-back
                5: begin
                    if (din == CMD_SECTOR && !locked) mem.delete(key);
                    step = 0;
                end
                10: begin
                    if (!locked) mem[key] = din;
                    step = 0;
                end
                default: step = 0;
            endcase
        end
    end
endmodule
